//--- include/spb_pkg.sv
package spb_pkg;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] SPB_ADDR_CTRL  = 8'h98;
  localparam logic [7:0] SPB_ADDR_DATA  = 8'h99;
  localparam logic [7:0] SPB_ADDR_PWR   = 8'h87;
  localparam logic [7:0] SPB_ADDR_T2CTL = 8'hC8;
  localparam logic [7:0] SPB_ADDR_RLD_L = 8'hCA;
  localparam logic [7:0] SPB_ADDR_RLD_H = 8'hCB;
  localparam logic [7:0] SPB_ADDR_CNT_L = 8'hCC;
  localparam logic [7:0] SPB_ADDR_CNT_H = 8'hCD;
  localparam logic [7:0] SPB_ADDR_SLAVE_ADDRESS_REGISTER = 8'hA9;
  localparam logic [7:0] SPB_ADDR_SMASK = 8'hB9;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SPB_CTL_MODE0 = 7;
  localparam int SPB_CTL_MODE1 = 6;
  localparam int SPB_CTL_MP    = 5;
  localparam int SPB_CTL_REN   = 4;
  localparam int SPB_CTL_TB8   = 3;
  localparam int SPB_CTL_RB8   = 2;
  localparam int SPB_CTL_TI    = 1;
  localparam int SPB_CTL_RI    = 0;
  localparam int SPB_PWR_DBL   = 7;
  localparam int SPB_PWR_FESEL = 6;
  localparam int SPB_T2_TF     = 7;
  localparam int SPB_T2_EXF    = 6;
  localparam int SPB_T2_RCLK   = 5;
  localparam int SPB_T2_TX_BAUD_SOURCE_SELECT   = 4;
  localparam int SPB_T2_EXEN   = 3;
  localparam int SPB_T2_RUN    = 2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  SPB_CTRL_RST = 8'h00;
  localparam logic [7:0]  SPB_T2_RST   = 8'h00;
  localparam logic [7:0]  SPB_ADDR_RST = 8'h00;
  localparam logic [15:0] SPB_RLD_RST  = 16'h0000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam logic [3:0] SPB_PH_S1P1  = 4'h0;
  localparam logic [3:0] SPB_PH_S3P1  = 4'h4;
  localparam logic [3:0] SPB_PH_S6P1  = 4'hA;
  localparam logic [3:0] SPB_PH_S6P2  = 4'hB;
  localparam logic [3:0] SPB_PH_LOWLO = 4'h4;
  localparam logic [3:0] SPB_PH_LOWHI = 4'h9;
  localparam logic [6:0] SPB_RX0_INIT = 7'h7E;
  localparam logic [2:0] SPB_MODE2_DIV = 3'h4;
  localparam logic [3:0] SPB_TICK_MID = 4'h7;
  localparam logic [3:0] SPB_TICK_END = 4'hF;
  localparam logic [3:0] SPB_STOP8    = 4'h9;
  localparam logic [3:0] SPB_STOP9    = 4'hA;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SPB_MODE_SHIFT  = 2'h0,
    SPB_MODE_UART8  = 2'h1,
    SPB_MODE_UART9F = 2'h2,
    SPB_MODE_UART9V = 2'h3
  } spb_mode_t;

  typedef enum logic [1:0] {
    SPB_RX_IDLE  = 2'h0,
    SPB_RX_START = 2'h1,
    SPB_RX_DATA  = 2'h3,
    SPB_RX_STOP  = 2'h2
  } spb_rx_state_t;

endpackage : spb_pkg

//--- hdl/spb_baud_gen.sv
`timescale 1ns/1ns
module spb_baud_gen (
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  input  wire logic        run_i,
  input  wire logic        clk6_mode_i,
  input  wire logic [15:0] reload_i,
  input  wire logic        load_low_i,
  input  wire logic        load_high_i,
  input  wire logic [7:0]  wdata_i,
  output logic      [15:0] count_o,
  output logic             rollover_o
);

  logic        half_r;
  logic [15:0] count_r;
  logic        roll_r;
  wire         inc   = run_i && (clk6_mode_i || half_r);
  wire         at_ff = (count_r == 16'hFFFF);

  // ----------------------------------------------------------------
  // counter: fosc in 6-clock mode, fosc/2 in 12-clock mode
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      half_r  <= 1'b0;
      count_r <= spb_pkg::SPB_RLD_RST;
      roll_r  <= 1'b0;
    end else begin
      half_r <= run_i ? ~half_r : 1'b0;
      roll_r <= inc && at_ff;
      if (load_low_i) begin
        count_r[7:0] <= wdata_i;
      end else if (load_high_i) begin
        count_r[15:8] <= wdata_i;
      end else if (inc) begin
        count_r <= at_ff ? reload_i : count_r + 16'h0001;
      end
    end
  end

  assign count_o    = count_r;
  assign rollover_o = roll_r;

endmodule : spb_baud_gen

//--- hdl/spb_serial_port.sv
`timescale 1ns/1ns
module spb_serial_port (
  input  wire logic       clock_i,
  input  wire logic       reset_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic       sfr_rd_i,
  input  wire logic [7:0] sfr_wdata_i,
  input  wire logic       clk6_mode_i,
  input  wire logic       timer1_ovf_i,
  input  wire logic       rxd_i,
  input  wire logic       second_timer_trigger_input_i,
  output logic      [7:0] sfr_rdata_o,
  output logic            txd_o,
  output logic            rxd_o,
  output logic            rxd_oe_n_o
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic at_phase(input logic [3:0] ph, input logic six, input logic [3:0] tgt);
    return six ? (ph == (tgt | 4'h1)) : (ph == tgt);
  endfunction : at_phase

  function automatic logic addr_hit(input logic [7:0] b, input logic [7:0] sa, input logic [7:0] sm);
    logic [7:0] bc;
    bc = sa | sm;
    return ((b & sm) == (sa & sm)) || ((b & bc) == bc);
  endfunction : addr_hit

  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7-i];
    end
    return r;
  endfunction : rev8

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic                      sm0_r, sm1_r, mp_r, ren_r, tb8_r, rb8_r, ti_r, ri_r, fe_r;
  logic                      dbl_r, fesel_r;
  logic [7:0]                t2ctl_r;
  logic [15:0]               rld_r;
  logic [7:0]                slave_address_register_r, smask_r, rbuf_r, rdata_r;
  logic [3:0]                ph_r;
  logic                      rxd_s1_r, rxd_s2_r, rxd_p_r;
  logic                      trg_s1_r, trg_s2_r, trg_p_r;
  logic [10:0]               tsr_r;
  logic [1:0]                tx0_arm_r;
  logic                      tx0_send_r, txa_busy_r;
  logic [3:0]                txa_cnt_r, txa_bit_r;
  logic [8:0]                rsr_r;
  logic                      rx0_go_r, rx0_act_r;
  spb_pkg::spb_rx_state_t    rx_st_r;
  logic [3:0]                rxa_cnt_r, rxa_bit_r;
  logic                      t1_half_r;
  logic [2:0]                m2_cnt_r;
  logic                      txd_r, rxd_out_r, rxd_oe_n_r;
  logic [15:0]               t2_count;
  logic                      t2_roll;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire wr_ctrl  = sfr_wr_i && (sfr_addr_i == spb_pkg::SPB_ADDR_CTRL);
  wire wr_data  = sfr_wr_i && (sfr_addr_i == spb_pkg::SPB_ADDR_DATA);
  wire wr_pwr   = sfr_wr_i && (sfr_addr_i == spb_pkg::SPB_ADDR_PWR);
  wire wr_t2    = sfr_wr_i && (sfr_addr_i == spb_pkg::SPB_ADDR_T2CTL);
  wire wr_rld_l = sfr_wr_i && (sfr_addr_i == spb_pkg::SPB_ADDR_RLD_L);
  wire wr_rld_h = sfr_wr_i && (sfr_addr_i == spb_pkg::SPB_ADDR_RLD_H);
  wire wr_cnt_l = sfr_wr_i && (sfr_addr_i == spb_pkg::SPB_ADDR_CNT_L);
  wire wr_cnt_h = sfr_wr_i && (sfr_addr_i == spb_pkg::SPB_ADDR_CNT_H);
  wire wr_sa    = sfr_wr_i && (sfr_addr_i == spb_pkg::SPB_ADDR_SLAVE_ADDRESS_REGISTER);
  wire wr_sm    = sfr_wr_i && (sfr_addr_i == spb_pkg::SPB_ADDR_SMASK);

  wire spb_pkg::spb_mode_t mode = spb_pkg::spb_mode_t'({sm0_r, sm1_r});
  wire is_m0 = (mode == spb_pkg::SPB_MODE_SHIFT);
  wire is_m1 = (mode == spb_pkg::SPB_MODE_UART8);
  wire is_m2 = (mode == spb_pkg::SPB_MODE_UART9F);

  wire [7:0] ctrl_rd = {fesel_r ? fe_r : sm0_r, sm1_r, mp_r, ren_r, tb8_r, rb8_r, ti_r, ri_r};
  wire [7:0] rd_val  =
    (sfr_addr_i == spb_pkg::SPB_ADDR_CTRL)  ? ctrl_rd :
    (sfr_addr_i == spb_pkg::SPB_ADDR_DATA)  ? rbuf_r :
    (sfr_addr_i == spb_pkg::SPB_ADDR_PWR)   ? {dbl_r, fesel_r, 6'h00} :
    (sfr_addr_i == spb_pkg::SPB_ADDR_T2CTL) ? t2ctl_r :
    (sfr_addr_i == spb_pkg::SPB_ADDR_RLD_L) ? rld_r[7:0] :
    (sfr_addr_i == spb_pkg::SPB_ADDR_RLD_H) ? rld_r[15:8] :
    (sfr_addr_i == spb_pkg::SPB_ADDR_CNT_L) ? t2_count[7:0] :
    (sfr_addr_i == spb_pkg::SPB_ADDR_CNT_H) ? t2_count[15:8] :
    (sfr_addr_i == spb_pkg::SPB_ADDR_SLAVE_ADDRESS_REGISTER) ? slave_address_register_r :
    (sfr_addr_i == spb_pkg::SPB_ADDR_SMASK) ? smask_r : 8'h00;

  // ----------------------------------------------------------------
  // machine cycle phases and bit rate ticks
  // ----------------------------------------------------------------
  wire ev_s1p1 = at_phase(ph_r, clk6_mode_i, spb_pkg::SPB_PH_S1P1);
  wire ev_s6p2 = at_phase(ph_r, clk6_mode_i, spb_pkg::SPB_PH_S6P2);
  wire sclk_lo = (ph_r >= spb_pkg::SPB_PH_LOWLO) && (ph_r <= spb_pkg::SPB_PH_LOWHI);
  wire [3:0] ph_nxt = clk6_mode_i ? ((ph_r >= 4'hA) ? 4'h1 : ((ph_r | 4'h1) + 4'h2))
                                  : ((ph_r >= spb_pkg::SPB_PH_S6P2) ? 4'h0 : ph_r + 4'h1);

  wire rclk     = t2ctl_r[spb_pkg::SPB_T2_RCLK];
  wire tx_baud_source_select     = t2ctl_r[spb_pkg::SPB_T2_TX_BAUD_SOURCE_SELECT];
  wire baud_gen = rclk || tx_baud_source_select;
  wire t2_run   = baud_gen && t2ctl_r[spb_pkg::SPB_T2_RUN];
  wire t1_tick  = timer1_ovf_i && (dbl_r || t1_half_r);
  wire [2:0] m2_lim = spb_pkg::SPB_MODE2_DIV >> ({1'b0, dbl_r} + {1'b0, clk6_mode_i});
  wire m2_tick  = (m2_cnt_r >= m2_lim - 3'h1);
  wire tx_tick  = is_m2 ? m2_tick : (tx_baud_source_select ? t2_roll : t1_tick);
  wire rx_tick  = is_m2 ? m2_tick : (rclk ? t2_roll : t1_tick);

  // ----------------------------------------------------------------
  // transmit
  // ----------------------------------------------------------------
  // marker at the output: the msb has had its full bit time and clock pulse
  wire       tx0_last = (tsr_r[10:1] == 10'h000);
  wire [3:0] stop_idx = is_m1 ? spb_pkg::SPB_STOP8 : spb_pkg::SPB_STOP9;
  wire       txa_step = txa_busy_r && tx_tick && (txa_cnt_r == spb_pkg::SPB_TICK_END);
  wire       ti_set   = (tx0_send_r && tx0_last && ev_s1p1)
                        || (txa_step && (txa_bit_r + 4'h1 == stop_idx));
  wire       tx_ninth = is_m1 ? 1'b1 : tb8_r;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      tsr_r      <= 11'h7FF;
      tx0_arm_r  <= 2'h0;
      tx0_send_r <= 1'b0;
      txa_busy_r <= 1'b0;
      txa_cnt_r  <= 4'h0;
      txa_bit_r  <= 4'h0;
    end else if (wr_data && is_m0) begin
      tsr_r      <= {2'h0, 1'b1, sfr_wdata_i};
      tx0_arm_r  <= 2'h2;
      tx0_send_r <= 1'b0;
    end else if (wr_data) begin
      tsr_r      <= {1'b1, tx_ninth, sfr_wdata_i, 1'b0};
      txa_busy_r <= 1'b1;
      txa_cnt_r  <= 4'h0;
      txa_bit_r  <= 4'h0;
    end else begin
      if (ev_s6p2 && (tx0_arm_r != 2'h0)) begin
        tx0_arm_r  <= tx0_arm_r - 2'h1;
        tx0_send_r <= (tx0_arm_r == 2'h1);
      end
      if (tx0_send_r && ev_s6p2 && !tx0_last) begin
        tsr_r <= {1'b0, tsr_r[10:1]};
      end else if (tx0_send_r && tx0_last && ev_s1p1) begin
        tsr_r      <= {1'b0, tsr_r[10:1]};
        tx0_send_r <= 1'b0;
      end
      if (txa_busy_r && tx_tick) begin
        txa_cnt_r <= txa_cnt_r + 4'h1;
      end
      if (txa_step) begin
        tsr_r     <= {1'b1, tsr_r[10:1]};
        txa_bit_r <= txa_bit_r + 4'h1;
        if (txa_bit_r == stop_idx) begin
          txa_busy_r <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // receive
  // ----------------------------------------------------------------
  wire       rx0_start = is_m0 && ren_r && !ri_r && !rx0_go_r && !rx0_act_r;
  wire       rx0_done  = rx0_act_r && ev_s6p2 && !rsr_r[7];
  wire       rxa_mid   = rx_tick && (rxa_cnt_r == spb_pkg::SPB_TICK_MID);
  wire       rxa_stop  = (rx_st_r == spb_pkg::SPB_RX_STOP) && rxa_mid;
  wire [7:0] rxa_byte  = is_m1 ? rsr_r[8:1] : rsr_r[7:0];
  wire       rxa_ninth = is_m1 ? rxd_s2_r : rsr_r[8];
  wire       rxa_hit   = addr_hit(rxa_byte, slave_address_register_r, smask_r);
  wire       rxa_mpok  = is_m1 ? (rxd_s2_r && rxa_hit) : (rsr_r[8] && rxa_hit);
  wire       rxa_take  = rxa_stop && !ri_r && (!mp_r || rxa_mpok);
  wire       ri_set    = rx0_done || rxa_take;
  wire       fe_set    = rxa_stop && !rxd_s2_r;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rsr_r     <= 9'h1FF;
      rx0_go_r  <= 1'b0;
      rx0_act_r <= 1'b0;
      rx_st_r   <= spb_pkg::SPB_RX_IDLE;
      rxa_cnt_r <= 4'h0;
      rxa_bit_r <= 4'h0;
      rbuf_r    <= 8'h00;
    end else begin
      rx0_go_r <= rx0_start && ev_s6p2;
      if (rx0_start && ev_s6p2) begin
        rsr_r <= {2'h3, spb_pkg::SPB_RX0_INIT};
      end
      if (rx0_go_r) begin
        rx0_act_r <= 1'b1;
      end
      if (rx0_act_r && ev_s6p2) begin
        rsr_r <= {rsr_r[7:0], rxd_s2_r};
        if (!rsr_r[7]) begin
          rx0_act_r <= 1'b0;
          rbuf_r    <= rev8({rsr_r[6:0], rxd_s2_r});
        end
      end
      if (rx_st_r != spb_pkg::SPB_RX_IDLE && rx_tick) begin
        rxa_cnt_r <= rxa_cnt_r + 4'h1;
      end
      case (rx_st_r)
        spb_pkg::SPB_RX_IDLE: begin
          if (!is_m0 && ren_r && rxd_p_r && !rxd_s2_r) begin
            rx_st_r   <= spb_pkg::SPB_RX_START;
            rxa_cnt_r <= 4'h0;
            rxa_bit_r <= 4'h0;
          end
        end
        spb_pkg::SPB_RX_START: begin
          if (rxa_mid) begin
            rx_st_r <= rxd_s2_r ? spb_pkg::SPB_RX_IDLE : spb_pkg::SPB_RX_DATA;
          end
        end
        spb_pkg::SPB_RX_DATA: begin
          if (rxa_mid) begin
            rsr_r     <= {rxd_s2_r, rsr_r[8:1]};
            rxa_bit_r <= rxa_bit_r + 4'h1;
            if (rxa_bit_r == (is_m1 ? 4'h7 : 4'h8)) begin
              rx_st_r <= spb_pkg::SPB_RX_STOP;
            end
          end
        end
        spb_pkg::SPB_RX_STOP: begin
          if (rxa_mid) begin
            rx_st_r <= spb_pkg::SPB_RX_IDLE;
            if (rxa_take) begin
              rbuf_r <= rxa_byte;
            end
          end
        end
        default: rx_st_r <= spb_pkg::SPB_RX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // software registers; hardware set wins over software clear
  // ----------------------------------------------------------------
  wire trg_fall = trg_p_r && !trg_s2_r;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      {sm0_r, sm1_r, mp_r, ren_r, tb8_r, rb8_r, ti_r, ri_r} <= spb_pkg::SPB_CTRL_RST;
      fe_r    <= 1'b0;
      dbl_r   <= 1'b0;
      fesel_r <= 1'b0;
      t2ctl_r <= spb_pkg::SPB_T2_RST;
      rld_r   <= spb_pkg::SPB_RLD_RST;
      slave_address_register_r <= spb_pkg::SPB_ADDR_RST;
      smask_r <= spb_pkg::SPB_ADDR_RST;
    end else begin
      if (wr_ctrl) begin
        if (fesel_r) begin
          fe_r <= sfr_wdata_i[spb_pkg::SPB_CTL_MODE0];
        end else begin
          sm0_r <= sfr_wdata_i[spb_pkg::SPB_CTL_MODE0];
        end
        {sm1_r, mp_r, ren_r, tb8_r, rb8_r, ti_r, ri_r} <= sfr_wdata_i[6:0];
      end
      if (wr_pwr) begin
        dbl_r   <= sfr_wdata_i[spb_pkg::SPB_PWR_DBL];
        fesel_r <= sfr_wdata_i[spb_pkg::SPB_PWR_FESEL];
      end
      if (wr_t2) t2ctl_r <= sfr_wdata_i;
      if (wr_rld_l) rld_r[7:0] <= sfr_wdata_i;
      if (wr_rld_h) rld_r[15:8] <= sfr_wdata_i;
      if (wr_sa) slave_address_register_r <= sfr_wdata_i;
      if (wr_sm) smask_r <= sfr_wdata_i;
      if (ti_set) ti_r <= 1'b1;
      if (ri_set) ri_r <= 1'b1;
      if (fe_set) fe_r <= 1'b1;
      if (rxa_take && !is_m0) rb8_r <= rxa_ninth;
      // rollover goes only to the bit clocks, never to the overflow flag
      if (baud_gen && t2ctl_r[spb_pkg::SPB_T2_EXEN] && trg_fall) begin
        t2ctl_r[spb_pkg::SPB_T2_EXF] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // synchronisers, dividers and registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      ph_r       <= spb_pkg::SPB_PH_S1P1;
      {rxd_s1_r, rxd_s2_r, rxd_p_r} <= 3'h7;
      {trg_s1_r, trg_s2_r, trg_p_r} <= 3'h7;
      t1_half_r  <= 1'b0;
      m2_cnt_r   <= 3'h0;
      txd_r      <= 1'b1;
      rxd_out_r  <= 1'b1;
      rxd_oe_n_r <= 1'b1;
      rdata_r    <= 8'h00;
    end else begin
      ph_r       <= ph_nxt;
      rxd_s1_r   <= rxd_i;
      rxd_s2_r   <= rxd_s1_r;
      rxd_p_r    <= rxd_s2_r;
      trg_s1_r   <= second_timer_trigger_input_i;
      trg_s2_r   <= trg_s1_r;
      trg_p_r    <= trg_s2_r;
      t1_half_r  <= timer1_ovf_i ? ~t1_half_r : t1_half_r;
      m2_cnt_r   <= m2_tick ? 3'h0 : m2_cnt_r + 3'h1;
      txd_r      <= is_m0 ? ((tx0_send_r || rx0_act_r) ? !sclk_lo : 1'b1)
                          : (txa_busy_r ? tsr_r[0] : 1'b1);
      rxd_out_r  <= tx0_send_r ? tsr_r[0] : 1'b1;
      rxd_oe_n_r <= !tx0_send_r;
      if (sfr_rd_i) rdata_r <= rd_val;
    end
  end

  spb_baud_gen u_baud_gen (
    .clock_i     (clock_i),
    .reset_i     (reset_i),
    .run_i       (t2_run),
    .clk6_mode_i (clk6_mode_i),
    .reload_i    (rld_r),
    .load_low_i  (wr_cnt_l),
    .load_high_i (wr_cnt_h),
    .wdata_i     (sfr_wdata_i),
    .count_o     (t2_count),
    .rollover_o  (t2_roll)
  );

  assign sfr_rdata_o = rdata_r;
  assign txd_o       = txd_r;
  assign rxd_o       = rxd_out_r;
  assign rxd_oe_n_o  = rxd_oe_n_r;

endmodule : spb_serial_port

//--- verif/spb_serial_port_chk.sv
`timescale 1ns/1ns
module spb_serial_port_chk (
  input wire logic       clock_i,
  input wire logic       reset_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic       sfr_rd_i,
  input wire logic       clk6_mode_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic       txd_o,
  input wire logic       rxd_o,
  input wire logic       rxd_oe_n_o
);
  // ------------------------------
  // mode 0 send and register reads
  // ------------------------------
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  logic [7:0] low_cnt_r;
  logic [3:0] fall_cnt_r;
  // length of the send window and shift clock pulses within it
  always_ff @(posedge clock_i) begin
    low_cnt_r  <= (reset_i || rxd_oe_n_o) ? 8'h00 : low_cnt_r + 8'h01;
    fall_cnt_r <= (reset_i || rxd_oe_n_o) ? 4'h0 : fall_cnt_r + {3'h0, $fell(txd_o)};
  end
  chk_send_length: assert property ($rose(rxd_oe_n_o) |-> low_cnt_r == (clk6_mode_i ? 8'h31 : 8'h61))
    else $error("mode 0 send window has wrong length");
  chk_send_bits: assert property ($rose(rxd_oe_n_o) |-> fall_cnt_r == 4'h8)
    else $error("mode 0 send gave wrong number of clocks");
  chk_clock_low: assert property ($fell(txd_o) && !rxd_oe_n_o && !clk6_mode_i |-> !txd_o [*6] ##1 txd_o)
    else $error("shift clock low phase wrong");
  chk_bit_period: assert property ($fell(txd_o) && !rxd_oe_n_o && !clk6_mode_i |-> ##12 ($fell(txd_o) || rxd_oe_n_o))
    else $error("mode 0 bit period wrong");
  chk_data_steady: assert property (!rxd_oe_n_o && $changed(rxd_o) |-> txd_o)
    else $error("send data moved while shift clock low");
  chk_unmapped_zero: assert property (sfr_rd_i && sfr_addr_i == 8'h00 |=> sfr_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  chk_read_hold: assert property (!sfr_rd_i |=> $stable(sfr_rdata_o))
    else $error("read data changed without a read");
  chk_no_ovf_flag: assert property (sfr_rd_i && sfr_addr_i == 8'hC8 |=> !sfr_rdata_o[7])
    else $error("timer overflow flag set in baud mode");
  cover property ($rose(rxd_oe_n_o));
  cover property (rxd_oe_n_o && $fell(txd_o));
  cover property (sfr_rd_i && sfr_addr_i == 8'h99);
endmodule : spb_serial_port_chk
bind spb_serial_port spb_serial_port_chk u_chk (.clock_i(clock_i), .reset_i(reset_i), .sfr_addr_i(sfr_addr_i),
  .sfr_rd_i(sfr_rd_i), .clk6_mode_i(clk6_mode_i), .sfr_rdata_o(sfr_rdata_o), .txd_o(txd_o),
  .rxd_o(rxd_o), .rxd_oe_n_o(rxd_oe_n_o));

//--- verif/spb_far_node.sv
`timescale 1ns/1ns
module spb_far_node (
  input  wire logic clock_i,
  input  wire logic txd_pin_i,
  input  wire logic pin_i,
  input  wire logic pin_oe_n_i,
  output logic      drive_o,
  output logic      drive_en_o
);
  // ------------------------------
  // shift register and uart node
  // ------------------------------
  logic [7:0] cap_r;
  logic [7:0] src_r;
  logic       src_on_r = 1'b0;
  initial begin
    drive_o    = 1'b1;
    drive_en_o = 1'b0;
  end
  // rising shift clock captures and moves the source to its next bit
  always @(posedge txd_pin_i) begin
    if (!pin_oe_n_i)
      cap_r <= {pin_i, cap_r[7:1]};
    if (src_on_r) begin
      src_r   <= {1'b1, src_r[7:1]};
      drive_o <= src_r[1];
    end
  end
  task automatic send_frame(input logic [10:0] bits, input int clks);
    drive_en_o <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      drive_o <= bits[i];
      repeat (clks) @(posedge clock_i);
    end
    drive_en_o <= 1'b0;
  endtask : send_frame
  task automatic recv_frame(input int clks, output logic [10:0] bits);
    @(negedge txd_pin_i);
    repeat (clks / 2) @(posedge clock_i);
    for (int i = 0; i < 11; i++) begin
      bits[i] = txd_pin_i;
      repeat (clks) @(posedge clock_i);
    end
  endtask : recv_frame
  task automatic load_shift(input logic [7:0] b);
    src_r      = b;
    src_on_r   = 1'b1;
    drive_o    <= b[0];
    drive_en_o <= 1'b1;
  endtask : load_shift
  // released line returns to the pull-up level
  task automatic release_line;
    src_on_r   = 1'b0;
    drive_en_o <= 1'b0;
  endtask : release_line
endmodule : spb_far_node

//--- verif/spb_serial_port_tb.sv
`timescale 1ns/1ns
`define SPB_CHECK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin n_fail++; \
  $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module spb_serial_port_tb;
  logic       clock_i = 1'b0;
  logic       reset_i = 1'b1;
  logic [7:0] sfr_addr_i = 8'h00;
  logic       sfr_wr_i = 1'b0;
  logic       sfr_rd_i = 1'b0;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic       timer1_ovf_i = 1'b0;
  logic       trig_i = 1'b1;
  logic       clk6 = 1'b0;
  logic [7:0] sfr_rdata_o;
  logic       txd_o, rxd_o, rxd_oe_n_o, drv, drv_en;
  int         n_fail = 0, check_count = 0, cycles = 0;
  wire        rxd_pin = !rxd_oe_n_o ? rxd_o : (drv_en ? drv : 1'b1);
  spb_serial_port uut (.clock_i(clock_i), .reset_i(reset_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
    .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i), .clk6_mode_i(clk6), .timer1_ovf_i(timer1_ovf_i),
    .rxd_i(rxd_pin), .second_timer_trigger_input_i(trig_i), .sfr_rdata_o(sfr_rdata_o), .txd_o(txd_o),
    .rxd_o(rxd_o), .rxd_oe_n_o(rxd_oe_n_o));
  spb_far_node far (.clock_i(clock_i), .txd_pin_i(txd_o), .pin_i(rxd_pin), .pin_oe_n_i(rxd_oe_n_o),
    .drive_o(drv), .drive_en_o(drv_en));
  initial forever #5 clock_i = ~clock_i;
  // ------------------------------
  // bus cycles and scenarios
  // ------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock_i);
    sfr_addr_i  <= a;
    sfr_wdata_i <= v;
    sfr_wr_i    <= 1'b1;
    @(posedge clock_i);
    sfr_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_i);
    sfr_addr_i <= a;
    sfr_rd_i   <= 1'b1;
    @(posedge clock_i);
    sfr_rd_i <= 1'b0;
    @(posedge clock_i);
    d = sfr_rdata_o;
  endtask : rd
  task automatic wait_flag(input int b, output logic [7:0] d);
    for (int i = 0; i < 300; i++) begin
      rd(8'h98, d);
      if (d[b] === 1'b1)
        break;
    end
  endtask : wait_flag
  task automatic t_regs;
    logic [7:0] d;
    wr(8'h00, 8'h55);
    rd(8'h00, d);
    rd(8'hA9, d);
    `SPB_CHECK("slave addr", 8'h00, d)
    rd(8'hB9, d);
    `SPB_CHECK("slave mask", 8'h00, d)
    rd(8'h98, d);
    `SPB_CHECK("control", 8'h00, d)
  endtask : t_regs
  task automatic t_mode0;
    logic [7:0] d;
    wr(8'h99, 8'hA5);
    wait_flag(1, d);
    `SPB_CHECK("shift out", 8'hA5, far.cap_r)
    `SPB_CHECK("tx flag m0", 1'b1, d[1])
    far.load_shift(8'h3C);
    wr(8'h98, 8'h10);
    wait_flag(0, d);
    wr(8'h98, 8'h00);
    far.release_line();
    rd(8'h99, d);
    `SPB_CHECK("shift in", 8'h3C, d)
  endtask : t_mode0
  task automatic t_async;
    logic [10:0] f;
    logic [7:0]  d;
    wr(8'h87, 8'h80);
    wr(8'h98, 8'h88);
    wr(8'h99, 8'h5A);
    far.recv_frame(32, f);
    `SPB_CHECK("mode2 frame", {2'h3, 8'h5A, 1'b0}, f)
    rd(8'h98, d);
    `SPB_CHECK("tx flag", 1'b1, d[1])
    wr(8'hCA, 8'hFE);
    wr(8'hCB, 8'hFF);
    wr(8'hCC, 8'hFE);
    wr(8'hCD, 8'hFF);
    wr(8'hC8, 8'h1C);
    wr(8'h98, 8'hC0);
    wr(8'h99, 8'hC3);
    far.recv_frame(64, f);
    `SPB_CHECK("mode3 frame", {2'h2, 8'hC3, 1'b0}, f)
    trig_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    rd(8'hC8, d);
    `SPB_CHECK("timer flags", 2'h1, d[7:6])
  endtask : t_async
  task automatic t_addr;
    logic [7:0] byt [4] = '{8'h12, 8'hC2, 8'hC2, 8'hFF};
    logic [3:0] nin = 4'hB;
    logic [7:0] sa = 8'hC0;
    logic [7:0] sm = 8'hFD;
    logic [7:0] d;
    logic [3:0] hits = 4'hA;
    wr(8'hA9, sa);
    wr(8'hB9, sm);
    for (int i = 0; i < 4; i++) begin
      wr(8'h98, 8'hF0);
      far.send_frame({1'b1, nin[i], byt[i], 1'b0}, 32);
      rd(8'h98, d);
      `SPB_CHECK("address match", hits[i], d[0])
    end
    `SPB_CHECK("ninth rx", 1'b1, d[2])
    rd(8'h99, d);
    `SPB_CHECK("broadcast data", 8'hFF, d)
    wr(8'h87, 8'hC0);
    far.send_frame(11'h066, 32);
    rd(8'h98, d);
    `SPB_CHECK("framing error", 1'b1, d[7])
    wr(8'h98, 8'h70);
    rd(8'h98, d);
    `SPB_CHECK("framing cleared", 1'b0, d[7])
    wr(8'h87, 8'h80);
    rd(8'h98, d);
    `SPB_CHECK("mode bit kept", 1'b1, d[7])
  endtask : t_addr
  task automatic t_six;
    logic [10:0] f;
    logic [7:0]  d;
    reset_i <= 1'b1;
    clk6    <= 1'b1;
    repeat (8) @(posedge clock_i);
    reset_i <= 1'b0;
    wr(8'h99, 8'h96);
    wait_flag(1, d);
    `SPB_CHECK("shift out 6clk", 8'h96, far.cap_r)
    wr(8'h87, 8'h80);
    wr(8'h98, 8'h80);
    wr(8'h99, 8'h3B);
    far.recv_frame(16, f);
    `SPB_CHECK("mode2 frame 6clk", {2'h2, 8'h3B, 1'b0}, f)
    repeat (16) @(posedge clock_i);
    wr(8'h98, 8'h70);
    far.send_frame({2'h3, 8'h12, 1'b0}, 32);
    rd(8'h98, d);
    `SPB_CHECK("mode1 rx flag", 1'b1, d[0])
    rd(8'h99, d);
    `SPB_CHECK("mode1 data", 8'h12, d)
    wr(8'h98, 8'h70);
    far.send_frame({2'h2, 8'h34, 1'b0}, 32);
    rd(8'h98, d);
    `SPB_CHECK("mode1 bad stop", 1'b0, d[0])
  endtask : t_six
  task automatic test_done;
    if (n_fail == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done
  always @(posedge clock_i) begin
    timer1_ovf_i <= ~timer1_ovf_i;
    cycles++;
    if (cycles == 40000) begin
      n_fail++;
      test_done();
    end
  end
  initial begin
    repeat (8) @(posedge clock_i);
    reset_i <= 1'b0;
    t_regs();
    t_mode0();
    t_async();
    t_addr();
    t_six();
    test_done();
  end
endmodule : spb_serial_port_tb
